/* File: pinmux_pkg.sv */
// Purpose: Shared constants and types for pin routing and trace
// Assumes: 12 pins: PA01..PA04, PC00..PC05, PD00, PD01
// Notes:   Signal codes are grouped by which ports accept them
package pinmux_pkg;
   // ------------------------------------------------------------
   // Pins
   // ------------------------------------------------------------
   localparam int NUM_PINS = 12;
   localparam int PA_LAST  = 3;
   localparam int PC_LAST  = 9;
   localparam int PIN_SWCLK = 0;
   localparam int PIN_SWDIO = 1;
   localparam int PIN_TDO   = 2;
   localparam int PIN_TDI   = 3;
   localparam int NUM_SYNC  = 16;
   localparam int SY_RST_N  = 12;
   localparam int SY_TCLK   = 13;
   localparam int SY_TDAT   = 14;
   localparam int SY_TFRM   = 15;
   // ------------------------------------------------------------
   // Signal codes on the digital route bus
   // ------------------------------------------------------------
   localparam int SEL_W = 7;
   localparam logic [SEL_W-1:0] SEL_NONE  = 7'h00;
   localparam logic [SEL_W-1:0] ALL_FIRST = 7'h01;
   localparam logic [SEL_W-1:0] ALL_LAST  = 7'h1a;
   localparam logic [SEL_W-1:0] A_FIRST   = 7'h1b;
   localparam logic [SEL_W-1:0] A_LAST    = 7'h2f;
   localparam logic [SEL_W-1:0] CD_FIRST  = 7'h30;
   localparam logic [SEL_W-1:0] CD_LAST   = 7'h46;
   localparam int NUM_SIGS = 71;
   localparam logic [SEL_W-1:0] SIG_TRACE_CLK  = 7'h33;
   localparam logic [SEL_W-1:0] SIG_TRACE_SYNC = 7'h34;
   localparam logic [SEL_W-1:0] SIG_TRACE_DATA = 7'h35;
   // ------------------------------------------------------------
   // Trace timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS  = 10;
   localparam int TRACE_HALF_NS  = 20;
   localparam int TRACE_HALF_CYC = (TRACE_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TRACE_BITS     = 8;
   localparam int FIFO_DEPTH     = 8;
   localparam logic [2:0] BIT_LAST = 3'h7;

   typedef struct packed {
      logic       frame_start;
      logic [7:0] data;
   } trace_word_t;

   typedef enum logic
   {
      SER_IDLE  = 1'b0,
      SER_SHIFT = 1'b1
   } ser_state_t;

   // Port that owns a pin: A for pins up to PA_LAST, otherwise C or D
   function automatic logic sel_legal(input logic [SEL_W-1:0] sel, input int pin);
      logic on_a;
      on_a = (pin <= PA_LAST);
      sel_legal = 1'b0;
      if (sel >= ALL_FIRST && sel <= ALL_LAST)
         sel_legal = 1'b1;
      else if (sel >= A_FIRST && sel <= A_LAST)
         sel_legal = on_a;
      else if (sel >= CD_FIRST && sel <= CD_LAST)
         sel_legal = !on_a;
   endfunction
endpackage

/* File: trace_fifo.sv */
// Purpose: Small FIFO for captured trace words
// Assumes: DEPTH is a power of two
// Notes:   Full and empty are derived from an occupancy count
`timescale 1ns/100ps
module trace_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
)(
   // Clock and reset
   input  wire logic             clk_sys_in,
   input  wire logic             rst_in,
   // Fill side
   input  wire logic             wr_valid_in,
   output logic                  wr_ready_out,
   input  wire logic [WIDTH-1:0] wr_data_in,
   // Drain side
   output logic                  rd_valid_out,
   input  wire logic             rd_ready_in,
   output logic [WIDTH-1:0]      rd_data_out
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wp_r;
   logic [AW-1:0]    rp_r;
   logic [AW:0]      count_r;
   logic             push;
   logic             pop;

   assign wr_ready_out = (count_r != FULL_CNT);
   assign rd_valid_out = (count_r != '0);
   assign rd_data_out  = mem_r[rp_r];
   assign push         = wr_valid_in && wr_ready_out;
   assign pop          = rd_valid_out && rd_ready_in;

   always_ff @(posedge clk_sys_in)
   begin
      if (push)
         mem_r[wp_r] <= wr_data_in;
   end

   always_ff @(posedge clk_sys_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         wp_r    <= '0;
         rp_r    <= '0;
         count_r <= '0;
      end
      else
      begin
         if (push)
            wp_r <= wp_r + 1'b1;
         if (pop)
            rp_r <= rp_r + 1'b1;
         if (push && !pop)
            count_r <= count_r + 1'b1;
         else if (pop && !push)
            count_r <= count_r - 1'b1;
      end
   end

   fifo_bound_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      count_r <= FULL_CNT) else $error("fifo count above depth");
endmodule

/* File: pin_router.sv */
// Purpose: Debug pin setup, reset gathering, pin routing, trace output
// Assumes: Select, enable and peripheral signals are on clk_sys_in
// Notes:   por_in clears only the sticky debug mode
`timescale 1ns/100ps
module pin_router (
   // Clock and resets
   input  wire logic                      clk_sys_in,
   input  wire logic                      rst_in,
   input  wire logic                      por_in,
   // Reset sources
   input  wire logic                      reset_pin_n_in,
   input  wire logic                      watchdog_expire_in,
   input  wire logic                      sw_reset_in,
   output logic                           sys_reset_out,
   // Debug control and core side
   input  wire logic                      jtag_sel_in,
   input  wire logic                      tdi_en_in,
   input  wire logic                      tdo_en_in,
   input  wire logic                      tdo_in,
   input  wire logic                      swdio_dout_in,
   input  wire logic                      swdio_drive_in,
   output logic                           jtag_mode_out,
   output logic                           dbg_clk_out,
   output logic                           dbg_tms_swdio_out,
   output logic                           dbg_tdi_out,
   // Routing
   input  wire logic [11:0][6:0]          pin_sel_in,
   input  wire logic [11:0]               gpio_dout_in,
   input  wire logic [11:0]               gpio_drive_in,
   input  wire logic [70:0]               periph_dout_in,
   input  wire logic [70:0]               periph_drive_in,
   output logic [70:0]                    periph_din_out,
   // Pins
   input  wire logic [11:0]               pin_in,
   output logic [11:0]                    pin_out,
   output logic [11:0]                    pin_oe_n_out,
   output logic [11:0]                    pull_up_out,
   output logic [11:0]                    pull_down_out,
   // Packet trace unit link
   input  wire logic                      trace_clk_in,
   input  wire logic                      frame_ctrl_data_out,
   input  wire logic                      frame_ctrl_frame_out,
   input  wire logic                      trace_ovf_clr_in,
   output logic                           trace_ready_out,
   output logic                           trace_overflow_out
);
   localparam int NP = pinmux_pkg::NUM_PINS;
   localparam int NS = pinmux_pkg::NUM_SIGS;

   // ------------------------------------------------------------
   // Synchronisers
   // ------------------------------------------------------------
   logic [15:0] sync1_r;
   logic [15:0] sync_r;

   always_ff @(posedge clk_sys_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         sync1_r <= 16'h1000;
         sync_r  <= 16'h1000;
      end
      else
      begin
         sync1_r <= {frame_ctrl_frame_out, frame_ctrl_data_out, trace_clk_in, reset_pin_n_in, pin_in};
         sync_r  <= sync1_r;
      end
   end

   // ------------------------------------------------------------
   // Reset sources and debug pin state
   // ------------------------------------------------------------
   logic rst_req;
   logic jtag_mode_r;
   logic tdi_en_r;
   logic tdo_en_r;
   logic tdi_active;
   logic tdo_active;

   assign rst_req    = !sync_r[pinmux_pkg::SY_RST_N] || watchdog_expire_in || sw_reset_in;
   assign tdi_active = jtag_mode_r && tdi_en_r;
   assign tdo_active = jtag_mode_r && tdo_en_r;

   always_ff @(posedge clk_sys_in or posedge rst_in)
   begin
      if (rst_in)
         sys_reset_out <= 1'b0;
      else
         sys_reset_out <= rst_req;
   end

   always_ff @(posedge clk_sys_in or posedge por_in)
   begin
      if (por_in)
         jtag_mode_r <= 1'b0;
      else if (jtag_sel_in)
         jtag_mode_r <= 1'b1;
   end

   always_ff @(posedge clk_sys_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         tdi_en_r <= 1'b0;
         tdo_en_r <= 1'b0;
      end
      else if (rst_req)
      begin
         tdi_en_r <= 1'b0;
         tdo_en_r <= 1'b0;
      end
      else
      begin
         if (tdi_en_in)
            tdi_en_r <= 1'b1;
         if (tdo_en_in)
            tdo_en_r <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         jtag_mode_out     <= 1'b0;
         dbg_clk_out       <= 1'b0;
         dbg_tms_swdio_out <= 1'b1;
         dbg_tdi_out       <= 1'b1;
      end
      else
      begin
         jtag_mode_out     <= jtag_mode_r;
         dbg_clk_out       <= sync_r[pinmux_pkg::PIN_SWCLK];
         dbg_tms_swdio_out <= sync_r[pinmux_pkg::PIN_SWDIO];
         dbg_tdi_out       <= tdi_active ? sync_r[pinmux_pkg::PIN_TDI] : 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Trace capture from the frame controller
   // ------------------------------------------------------------
   logic                    tclk_d_r;
   logic                    frm_prev_r;
   logic [2:0]              cnt_r;
   logic [7:0]              sh_r;
   logic                    start_r;
   logic                    wr_valid_r;
   pinmux_pkg::trace_word_t wr_word_r;
   pinmux_pkg::trace_word_t rd_word;
   logic                    fifo_wr_ready;
   logic                    fifo_rd_valid;
   logic                    fifo_rd_ready;
   logic                    bit_take;
   logic                    first_bit;
   logic [2:0]              cnt_nxt;
   logic [7:0]              sh_nxt;

   assign bit_take  = sync_r[pinmux_pkg::SY_TCLK] && !tclk_d_r && sync_r[pinmux_pkg::SY_TFRM];
   assign first_bit = !frm_prev_r;
   assign cnt_nxt   = first_bit ? 3'h0 : cnt_r;
   assign sh_nxt    = {sync_r[pinmux_pkg::SY_TDAT], sh_r[7:1]};

   // Capture runs free; a full FIFO drops words rather than stalling
   always_ff @(posedge clk_sys_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         tclk_d_r   <= 1'b0;
         frm_prev_r <= 1'b0;
         cnt_r      <= 3'h0;
         sh_r       <= 8'h00;
         start_r    <= 1'b0;
         wr_valid_r <= 1'b0;
         wr_word_r  <= '0;
      end
      else
      begin
         tclk_d_r   <= sync_r[pinmux_pkg::SY_TCLK];
         wr_valid_r <= 1'b0;
         // Frame low arms a fresh word for the next frame
         if (!sync_r[pinmux_pkg::SY_TFRM])
            frm_prev_r <= 1'b0;
         else if (sync_r[pinmux_pkg::SY_TCLK] && !tclk_d_r)
            frm_prev_r <= 1'b1;
         if (bit_take)
         begin
            sh_r  <= sh_nxt;
            cnt_r <= cnt_nxt + 3'h1;
            if (cnt_nxt == pinmux_pkg::BIT_LAST)
            begin
               wr_valid_r <= 1'b1;
               wr_word_r  <= {start_r || first_bit, sh_nxt};
               start_r    <= 1'b0;
            end
            else if (first_bit)
               start_r <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         trace_overflow_out <= 1'b0;
         trace_ready_out    <= 1'b1;
      end
      else
      begin
         trace_ready_out <= fifo_wr_ready;
         if (wr_valid_r && !fifo_wr_ready)
            trace_overflow_out <= 1'b1;
         else if (trace_ovf_clr_in)
            trace_overflow_out <= 1'b0;
      end
   end

   trace_fifo #(
      .WIDTH ($bits(pinmux_pkg::trace_word_t)),
      .DEPTH (pinmux_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk_sys_in   (clk_sys_in),
      .rst_in       (rst_in),
      .wr_valid_in  (wr_valid_r),
      .wr_ready_out (fifo_wr_ready),
      .wr_data_in   (wr_word_r),
      .rd_valid_out (fifo_rd_valid),
      .rd_ready_in  (fifo_rd_ready),
      .rd_data_out  (rd_word)
   );

   // ------------------------------------------------------------
   // Trace serialiser, stalls while no pin carries trace data
   // ------------------------------------------------------------
   pinmux_pkg::ser_state_t state_r;
   logic [7:0]             ser_sh_r;
   logic [2:0]             ser_bit_r;
   logic [1:0]             div_r;
   logic                   trace_clk_r;
   logic                   trace_data_r;
   logic                   trace_sync_r;
   logic                   trace_routed;
   logic                   half_done;

   assign fifo_rd_ready = (state_r == pinmux_pkg::SER_IDLE) && trace_routed;
   assign half_done     = (div_r == 2'(pinmux_pkg::TRACE_HALF_CYC - 1));

   always_ff @(posedge clk_sys_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         state_r      <= pinmux_pkg::SER_IDLE;
         ser_sh_r     <= 8'h00;
         ser_bit_r    <= 3'h0;
         div_r        <= 2'h0;
         trace_clk_r  <= 1'b0;
         trace_data_r <= 1'b0;
         trace_sync_r <= 1'b0;
      end
      else
      begin
         case (state_r)
            pinmux_pkg::SER_IDLE:
            begin
               trace_sync_r <= 1'b0;
               if (fifo_rd_valid && fifo_rd_ready)
               begin
                  state_r      <= pinmux_pkg::SER_SHIFT;
                  ser_sh_r     <= rd_word.data;
                  ser_bit_r    <= 3'h0;
                  div_r        <= 2'h0;
                  trace_data_r <= rd_word.data[0];
                  trace_sync_r <= rd_word.frame_start;
               end
            end
            pinmux_pkg::SER_SHIFT:
            begin
               div_r <= half_done ? 2'h0 : div_r + 2'h1;
               if (half_done)
               begin
                  trace_clk_r <= !trace_clk_r;
                  if (trace_clk_r)
                  begin
                     trace_sync_r <= 1'b0;
                     ser_bit_r    <= ser_bit_r + 3'h1;
                     trace_data_r <= ser_sh_r[ser_bit_r + 3'h1];
                     if (ser_bit_r == pinmux_pkg::BIT_LAST)
                        state_r <= pinmux_pkg::SER_IDLE;
                  end
               end
            end
            default:
               state_r <= pinmux_pkg::SER_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Pin routing
   // ------------------------------------------------------------
   logic [NS-1:0] sig_dout;
   logic [NS-1:0] sig_drive;
   logic [NP-1:0] dout_nxt;
   logic [NP-1:0] oe_n_nxt;
   logic [NP-1:0] pu_nxt;
   logic [NP-1:0] pd_nxt;
   logic [NS-1:0] din_nxt;

   always_comb
   begin
      sig_dout  = periph_dout_in;
      sig_drive = periph_drive_in;
      sig_dout[pinmux_pkg::SIG_TRACE_CLK]   = trace_clk_r;
      sig_dout[pinmux_pkg::SIG_TRACE_SYNC]  = trace_sync_r;
      sig_dout[pinmux_pkg::SIG_TRACE_DATA]  = trace_data_r;
      sig_drive[pinmux_pkg::SIG_TRACE_CLK]  = 1'b1;
      sig_drive[pinmux_pkg::SIG_TRACE_SYNC] = 1'b1;
      sig_drive[pinmux_pkg::SIG_TRACE_DATA] = 1'b1;
      trace_routed = 1'b0;
      din_nxt      = '0;
      pu_nxt       = '0;
      pd_nxt       = '0;
      for (int i = 0; i < NP; i++)
      begin
         if (pinmux_pkg::sel_legal(pin_sel_in[i], i))
         begin
            dout_nxt[i] = sig_dout[pin_sel_in[i]];
            oe_n_nxt[i] = !sig_drive[pin_sel_in[i]];
            din_nxt[pin_sel_in[i]] = din_nxt[pin_sel_in[i]] | sync_r[i];
            if (pin_sel_in[i] == pinmux_pkg::SIG_TRACE_DATA)
               trace_routed = 1'b1;
         end
         else
         begin
            dout_nxt[i] = gpio_dout_in[i];
            oe_n_nxt[i] = !gpio_drive_in[i];
         end
      end
      // Debug functions take their pins over from routing
      dout_nxt[pinmux_pkg::PIN_SWCLK] = 1'b0;
      oe_n_nxt[pinmux_pkg::PIN_SWCLK] = 1'b1;
      pd_nxt[pinmux_pkg::PIN_SWCLK]   = 1'b1;
      dout_nxt[pinmux_pkg::PIN_SWDIO] = swdio_dout_in;
      oe_n_nxt[pinmux_pkg::PIN_SWDIO] = jtag_mode_r || !swdio_drive_in;
      pu_nxt[pinmux_pkg::PIN_SWDIO]   = 1'b1;
      if (tdo_active)
      begin
         dout_nxt[pinmux_pkg::PIN_TDO] = tdo_in;
         oe_n_nxt[pinmux_pkg::PIN_TDO] = 1'b0;
      end
      if (tdi_active)
      begin
         dout_nxt[pinmux_pkg::PIN_TDI] = 1'b0;
         oe_n_nxt[pinmux_pkg::PIN_TDI] = 1'b1;
         pu_nxt[pinmux_pkg::PIN_TDI]   = 1'b1;
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         pin_out        <= '0;
         pin_oe_n_out   <= '1;
         pull_up_out    <= 12'h002;
         pull_down_out  <= 12'h001;
         periph_din_out <= '0;
      end
      else
      begin
         pin_out        <= dout_nxt;
         pin_oe_n_out   <= oe_n_nxt;
         pull_up_out    <= pu_nxt;
         pull_down_out  <= pd_nxt;
         periph_din_out <= din_nxt;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   tdi_enable_pull_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      tdi_active |=> pull_up_out[pinmux_pkg::PIN_TDI]) else $error("tdi pull-up missing");
   tdo_reset_off_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      rst_req |=> !tdo_en_r && !tdi_en_r) else $error("tdo enabled after reset");
   swdio_pull_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      rst_req |-> ##2 pull_up_out[pinmux_pkg::PIN_SWDIO]) else $error("swdio pull-up missing");
   swclk_pull_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      rst_req |-> ##2 (pull_down_out[pinmux_pkg::PIN_SWCLK] && pin_oe_n_out[pinmux_pkg::PIN_SWCLK]))
      else $error("swclk not an input with pull-down");
   jtag_select_a: assert property (@(posedge clk_sys_in) disable iff (rst_in || por_in)
      jtag_sel_in |-> ##2 jtag_mode_out) else $error("jtag mode not taken");
   jtag_sticky_a: assert property (@(posedge clk_sys_in) disable iff (por_in)
      jtag_mode_r |=> jtag_mode_r) else $error("jtag mode lost without power cycle");
   reset_source_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (watchdog_expire_in || sw_reset_in) |=> sys_reset_out) else $error("reset source ignored");
   trace_drop_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (wr_valid_r && !fifo_wr_ready) |=> trace_overflow_out) else $error("dropped word not flagged");
   trace_route_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (pin_sel_in[4] == pinmux_pkg::SIG_TRACE_DATA) |=> pin_out[4] == $past(trace_data_r))
      else $error("trace data not on pin");
   all_port_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (pin_sel_in[10] == pinmux_pkg::ALL_FIRST) |=> pin_out[10] == $past(periph_dout_in[1]))
      else $error("routed signal missing");
   bad_sel_gpio_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (pin_sel_in[4] == pinmux_pkg::A_FIRST) |=> pin_out[4] == $past(gpio_dout_in[4]))
      else $error("unsupported selection took effect");

   word_sent_c: cover property (@(posedge clk_sys_in) disable iff (rst_in)
      state_r == pinmux_pkg::SER_SHIFT && trace_sync_r);
   overflow_c: cover property (@(posedge clk_sys_in) disable iff (rst_in)
      $rose(trace_overflow_out));
   jtag_c: cover property (@(posedge clk_sys_in) disable iff (rst_in)
      tdo_active && tdi_active);
endmodule

/* File: trace_src.sv */
// Purpose: Packet trace link source facing the trace capture inputs
// Assumes: Link clock period 160 ns, clock idle low between frames
// Notes:   Data line shows the inverse of its last bit once idle
`timescale 1ns/100ps
module trace_src (
   // Trace link
   output logic trace_clk_out,
   output logic frame_out,
   output logic data_out
);
   initial
   begin
      trace_clk_out = 1'b0;
      frame_out     = 1'b0;
      data_out      = 1'b0;
   end
   // ----------------------------------------
   // One frame of eight bits, low bit first
   // ----------------------------------------
   task automatic send(input logic [7:0] b);
      frame_out = 1'b1;
      for (int i = 0; i < 8; i++)
      begin
         data_out = b[i];
         #80 trace_clk_out = 1'b1;
         #80 trace_clk_out = 1'b0;
      end
      frame_out = 1'b0;
      data_out  = ~b[7];
      #160;
   endtask
endmodule

/* File: debug_and_trace_pin_routing_tb_top.sv */
// Purpose: Self-checking bench for pin routing, debug pins and trace
// Assumes: 100 MHz system clock, trace link at 160 ns
// Notes:   Routing cases are table rows; debug and trace follow
`timescale 1ns/100ps
module debug_and_trace_pin_routing_tb_top;
   logic             clk_sys_in, rst_in, por_in, rpin_n, wdog, swr, jsel;
   logic             tdi_en, tdo_en, tdo, sw_do, sw_drv, clr;
   logic [11:0][6:0] sel;
   logic [11:0]      gdo, gdrv, pin_in, pin_out, oe_n, pu, pd;
   logic [70:0]      pdo, pdrv, pdi;
   logic             sys_rst, jtag, tclk, tfrm, tdat, rdy, ovf, dclk, dtms, dtdi, lsync;
   logic [7:0]       v;
   int               errors = 0;
   int               comparisons = 0;
   int               nsync;
   int               rows [8][3] = '{'{4'ha, 7'h01, 1'h1}, '{4'h4, 7'h1b, 1'h0}, '{4'hb, 7'h30, 1'h1},
      '{4'h2, 7'h2f, 1'h1}, '{4'h3, 7'h30, 1'h0}, '{4'h9, 7'h46, 1'h1}, '{4'h5, 7'h1a, 1'h1}, '{4'h2, 7'h47, 1'h0}};

   pin_router dut_u (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .por_in(por_in), .reset_pin_n_in(rpin_n),
      .watchdog_expire_in(wdog), .sw_reset_in(swr), .sys_reset_out(sys_rst), .jtag_sel_in(jsel),
      .tdi_en_in(tdi_en), .tdo_en_in(tdo_en), .tdo_in(tdo), .swdio_dout_in(sw_do), .swdio_drive_in(sw_drv),
      .jtag_mode_out(jtag), .dbg_clk_out(dclk), .dbg_tms_swdio_out(dtms), .dbg_tdi_out(dtdi), .pin_sel_in(sel),
      .gpio_dout_in(gdo), .gpio_drive_in(gdrv), .periph_dout_in(pdo), .periph_drive_in(pdrv),
      .periph_din_out(pdi), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n_out(oe_n), .pull_up_out(pu),
      .pull_down_out(pd), .trace_clk_in(tclk), .frame_ctrl_data_out(tdat), .frame_ctrl_frame_out(tfrm),
      .trace_ovf_clr_in(clr), .trace_ready_out(rdy), .trace_overflow_out(ovf));
   trace_src src_u (.trace_clk_out(tclk), .frame_out(tfrm), .data_out(tdat));

   initial
   begin
      clk_sys_in = 1'b0;
      forever #5 clk_sys_in = ~clk_sys_in;
   end
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic check(input string n, input logic [11:0] s, input logic [11:0] e);
      comparisons++;
      if (s !== e)
      begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic stop_test;
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys_in);
   endtask
   task automatic pulse(ref logic s);
      cyc(1);
      s = 1'b1;
      cyc(1);
      s = 1'b0;
   endtask
   task automatic rst_seen;
      int n;
      n = 0;
      while (sys_rst !== 1'b1 && n < 8)
      begin
         cyc(1);
         n++;
      end
      check("sys_reset", 12'(n < 8), 12'h001);
      if (n >= 8)
         stop_test;
      cyc(3);
   endtask
   task automatic mon;
      int k;
      int n;
      logic last;
      k = 0;
      n = 0;
      last = 1'b0;
      while (k < 8 && n < 600)
      begin
         cyc(1);
         n++;
         if (pin_out[6] === 1'b1 && !last)
         begin
            if (k == 0)
               check("sync", 12'(pin_out[5]), 12'h001);
            v[k] = pin_out[4];
            k++;
         end
         last = pin_out[6];
      end
      check("trace_byte", 12'(v), 12'h0a5);
      check("trace_bits", 12'(k), 12'h008);
      if (k < 8)
         stop_test;
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      {wdog, swr, jsel, tdi_en, tdo_en, tdo, sw_do, sw_drv, clr} = '0;
      {rst_in, por_in, rpin_n} = 3'h7;
      sel = '0;
      gdo = '0;
      gdrv = '0;
      pin_in = '0;
      pdo = '1;
      pdrv = '1;
      cyc(3);
      check("pull_up", pu, 12'h002);
      check("pull_down", pd, 12'h001);
      check("oe_n", oe_n, 12'hfff);
      check("dbg_reset", 12'({dclk, dtms, dtdi}), 12'h003);
      cyc(3);
      {rst_in, por_in} = 2'h0;
      pin_in = '1;
      cyc(2);
      foreach (rows[i])
      begin
         sel = '0;
         sel[rows[i][0]] = rows[i][1][6:0];
         cyc(3);
         check("route_oe_n", 12'(oe_n[rows[i][0]]), 12'(!rows[i][2]));
         if (rows[i][1] < pinmux_pkg::NUM_SIGS)
            check("route_din", 12'(pdi[rows[i][1]]), 12'(rows[i][2]));
      end
      sel = '0;
      pulse(jsel);
      cyc(3);
      check("jtag_mode", 12'(jtag), 12'h001);
      check("tdi_pull", 12'(pu[3]), 12'h000);
      check("tdo_oe_n", 12'(oe_n[2]), 12'h001);
      tdo = 1'b1;
      pulse(tdi_en);
      pulse(tdo_en);
      cyc(3);
      check("tdi_pull", 12'(pu[3]), 12'h001);
      check("tdo_pin", 12'({oe_n[2], pin_out[2]}), 12'h001);
      pin_in[3] = 1'b0;
      cyc(3);
      check("tdi_in", 12'({dclk, dtms, dtdi}), 12'h006);
      pulse(swr);
      rst_seen;
      check("jtag_kept", 12'(jtag), 12'h001);
      check("tdo_off", 12'(oe_n[2]), 12'h001);
      check("tdi_off", 12'(pu[3]), 12'h000);
      check("tdi_in_off", 12'(dtdi), 12'h001);
      pulse(wdog);
      rst_seen;
      rpin_n = 1'b0;
      cyc(4);
      rpin_n = 1'b1;
      rst_seen;
      pulse(por_in);
      cyc(3);
      check("jtag_cleared", 12'(jtag), 12'h000);
      sw_do = 1'b1;
      sw_drv = 1'b1;
      cyc(3);
      check("swdio_pin", 12'({oe_n[1], pin_out[1]}), 12'h001);
      sel[4] = pinmux_pkg::SIG_TRACE_DATA;
      sel[5] = pinmux_pkg::SIG_TRACE_SYNC;
      sel[6] = pinmux_pkg::SIG_TRACE_CLK;
      cyc(2);
      fork
         src_u.send(8'ha5);
         mon;
      join
      sel = '0;
      for (int i = 0; i < 8; i++)
         src_u.send(8'h3c);
      check("fifo_full", 12'({rdy, ovf}), 12'h000);
      src_u.send(8'h3c);
      check("overflow", 12'(ovf), 12'h001);
      pulse(clr);
      cyc(2);
      check("ovf_clear", 12'(ovf), 12'h000);
      sel[4] = pinmux_pkg::SIG_TRACE_DATA;
      sel[5] = pinmux_pkg::SIG_TRACE_SYNC;
      nsync = 0;
      lsync = 1'b0;
      repeat (400)
      begin
         cyc(1);
         if (pin_out[5] === 1'b1 && !lsync)
            nsync++;
         lsync = pin_out[5];
      end
      check("sync_count", 12'(nsync), 12'h008);
      check("fifo_drained", 12'(rdy), 12'h001);
      stop_test;
   end
endmodule
